// ==== core/rtcm_top.sv ====
// Top of the clock calendar register map with an APB slave.
// Assumes flags and battery status come from the timekeeping core outside.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rtcm_top #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status from the timekeeping core
  input wire logic update_pending_flag,
  input wire logic [3:0] irq_flag_bits,
  input wire logic battery_good_flag,
  // Control and alarm match out
  output logic data_format_select,
  output logic hour_24_select,
  output logic bank_select,
  output logic alarm_match
);
  logic [rtcm_pkg::IDX_W-1:0] idx;
  logic in_range;
  logic access;
  logic wr_stb;
  logic [7:0] wbyte;
  logic bank1_hit;
  logic [7:0] rbyte;
  logic rhit;
  logic [7:0] tb [rtcm_pkg::NUM_TIME_BYTES];
  logic [7:0] century_q;
  logic [7:0] alarm_date_q;
  logic [7:0] rate_q;
  logic [7:0] fmt_q;
  logic next_match;

  // Register index from word address; upper bits beyond index must be zero
  assign idx = paddr[rtcm_pkg::ADDR_LSB +: rtcm_pkg::IDX_W];
  assign in_range = (paddr[ADDR_W-1:rtcm_pkg::ADDR_LSB+rtcm_pkg::IDX_W] == '0);
  assign access = psel && penable && !pready;
  assign wr_stb = clk_en && access && pwrite && pstrb[0] && in_range;
  assign wbyte = pwdata[7:0];
  assign bank1_hit = rate_q[rtcm_pkg::RATE_BANK_BIT];

  // Ten time bytes; seconds bit 7 is fixed, others take any bits
  for (genvar g = 0; g < rtcm_pkg::NUM_TIME_BYTES; g++)
  begin : g_time
    rtcm_regs_if bus_i ();
    localparam logic [7:0] MSK = (g == 0) ? rtcm_pkg::SECONDS_WRITE_MASK : 8'hFF;
    assign bus_i.we = wr_stb && (idx == 8'(g));
    assign bus_i.wdata = wbyte;
    assign tb[g] = bus_i.q;
    rtcm_byte_reg #(.WMASK(MSK), .RESET_VAL(rtcm_pkg::DATA_RESET)) u_reg (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .port(bus_i)
    );
  end

  // Bank-one extended bytes and the two writable control bytes
  rtcm_regs_if cen_i ();
  rtcm_regs_if adt_i ();
  rtcm_regs_if rate_i ();
  rtcm_regs_if fmt_i ();
  assign cen_i.we = wr_stb && bank1_hit && (idx == rtcm_pkg::ADDR_CENTURY);
  assign adt_i.we = wr_stb && bank1_hit && (idx == rtcm_pkg::ADDR_ALARM_DATE);
  assign rate_i.we = wr_stb && (idx == rtcm_pkg::ADDR_RATE_CTRL);
  assign fmt_i.we = wr_stb && (idx == rtcm_pkg::ADDR_IRQ_FMT_CTRL);
  assign cen_i.wdata = wbyte;
  assign adt_i.wdata = wbyte;
  assign rate_i.wdata = wbyte;
  assign fmt_i.wdata = wbyte;
  assign century_q = cen_i.q;
  assign alarm_date_q = adt_i.q;
  assign rate_q = rate_i.q;
  assign fmt_q = fmt_i.q;

  rtcm_byte_reg #(.WMASK(8'hFF), .RESET_VAL(rtcm_pkg::DATA_RESET)) u_century (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .port(cen_i)
  );
  rtcm_byte_reg #(.WMASK(8'hFF), .RESET_VAL(rtcm_pkg::DATA_RESET)) u_alarm_date (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .port(adt_i)
  );
  // Pending flag bit is owned by the core, not by software
  rtcm_byte_reg #(.WMASK(rtcm_pkg::RATE_WRITE_MASK), .RESET_VAL(rtcm_pkg::RATE_RESET)) u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .port(rate_i)
  );
  rtcm_byte_reg #(.WMASK(8'hFF), .RESET_VAL(rtcm_pkg::FMT_RESET)) u_fmt (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .port(fmt_i)
  );

  // Read decode; flag and battery bytes have no storage so writes vanish
  always_comb
  begin
    rbyte = 8'h00;
    rhit = in_range;
    if (idx < 8'(rtcm_pkg::NUM_TIME_BYTES))
      rbyte = tb[idx[3:0]];
    else if (idx == rtcm_pkg::ADDR_RATE_CTRL)
      rbyte = {update_pending_flag, rate_q[6:0]};
    else if (idx == rtcm_pkg::ADDR_IRQ_FMT_CTRL)
      rbyte = fmt_q;
    else if (idx == rtcm_pkg::ADDR_IRQ_FLAGS)
      rbyte = {irq_flag_bits, 4'h0} & rtcm_pkg::FLAGS_READ_MASK;
    else if (idx == rtcm_pkg::ADDR_BATTERY)
      rbyte = {battery_good_flag, 7'h00} & rtcm_pkg::BATTERY_READ_MASK;
    else if (bank1_hit && idx == rtcm_pkg::ADDR_CENTURY)
      rbyte = century_q;
    else if (bank1_hit && idx == rtcm_pkg::ADDR_ALARM_DATE)
      rbyte = alarm_date_q;
    else
      rhit = 1'b0;
  end

  // Three-cycle APB: one wait state keeps pready registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= access;
      if (access)
      begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rbyte};
        pslverr <= !rhit;
      end
      else
        pslverr <= 1'b0;
    end
  end

  // Alarm compare; both top bits set is a wildcard
  function automatic logic alarm_hit(input logic [7:0] a, input logic [7:0] t);
    alarm_hit = (a[7:6] == rtcm_pkg::ALARM_ANY) || (a == t);
  endfunction : alarm_hit

  assign next_match = alarm_hit(tb[1], tb[0]) && alarm_hit(tb[3], tb[2])
    && alarm_hit(tb[5], tb[4]);

  // Registered control outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_format_select <= 1'b0;
      hour_24_select <= 1'b0;
      bank_select <= 1'b0;
      alarm_match <= 1'b0;
    end
    else if (clk_en)
    begin
      data_format_select <= fmt_q[rtcm_pkg::FMT_BINARY_BIT];
      hour_24_select <= fmt_q[rtcm_pkg::FMT_24H_BIT];
      bank_select <= rate_q[rtcm_pkg::RATE_BANK_BIT];
      alarm_match <= next_match;
    end
  end
endmodule : rtcm_top
`default_nettype wire

// ==== core/rtcm_pkg.sv ====
// Package for the clock calendar register map: offsets, fields, reset values.
// Assumes a 32-bit APB master; one register per aligned word.
// Summary of operation
// - In packed decimal mode the seconds, minutes and their alarms keep tens in bits 6..4, units in 3..0, bit 7 zero, range 00-59.
// - In decimal mode hours use bit 7 as the afternoon flag with tens in bit 4 for 12-hour form, or tens in bits 5..4 for 24-hour form.
// - Day, date, month and year sit at consecutive locations, with century and a date alarm in bank one.
// - In binary mode every time, calendar and alarm byte is a plain binary count.
// - Four control registers follow the year byte; the flag register reads zero in bits 3..0 and the battery register in bits 6..0.
// - Time and calendar bytes have no defined content at power-up; software initialises them. Here reset loads DATA_RESET, 00, into them.
// - Time and date bytes other than seconds accept ones in bit positions shown as zero.
// - Writes to the flag and battery registers, to bit 7 of the rate register and to bit 7 of seconds are ignored.
// - An alarm byte with both top bits set matches any value of its time byte.
// - The data-format selector picks binary when one, decimal when zero; the hour-format selector picks 24-hour when one.
// - Control registers appear in both banks; the bank-select bit exposes century and date alarm.
package rtcm_pkg;
  localparam logic [7:0] ADDR_SECONDS = 8'h00;
  localparam logic [7:0] ADDR_ALARM_SECONDS = 8'h01;
  localparam logic [7:0] ADDR_MINUTES = 8'h02;
  localparam logic [7:0] ADDR_ALARM_MINUTES = 8'h03;
  localparam logic [7:0] ADDR_HOURS = 8'h04;
  localparam logic [7:0] ADDR_ALARM_HOURS = 8'h05;
  localparam logic [7:0] ADDR_DAY_OF_WEEK = 8'h06;
  localparam logic [7:0] ADDR_DAY_OF_MONTH = 8'h07;
  localparam logic [7:0] ADDR_MONTH = 8'h08;
  localparam logic [7:0] ADDR_YEAR = 8'h09;
  localparam logic [7:0] ADDR_RATE_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_IRQ_FMT_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_BATTERY = 8'h0D;
  localparam logic [7:0] ADDR_CENTURY = 8'h48;
  localparam logic [7:0] ADDR_ALARM_DATE = 8'h49;
  // Register index is the printed offset; byte address is index times four
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  // Rate/divider control fields
  localparam int RATE_PENDING_BIT = 7;
  localparam int RATE_BANK_BIT = 4;
  localparam logic [7:0] RATE_WRITE_MASK = 8'h7F;
  localparam logic [7:0] RATE_RESET = 8'h20;
  // Interrupt/format control fields
  localparam int FMT_BINARY_BIT = 2;
  localparam int FMT_24H_BIT = 1;
  localparam logic [7:0] FMT_RESET = 8'h00;
  // Fixed read and write masks
  localparam logic [7:0] FLAGS_READ_MASK = 8'hF0;
  localparam logic [7:0] BATTERY_READ_MASK = 8'h80;
  localparam logic [7:0] SECONDS_WRITE_MASK = 8'h7F;
  localparam logic [1:0] ALARM_ANY = 2'b11;
  localparam int NUM_TIME_BYTES = 10;
  localparam logic [7:0] DATA_RESET = 8'h00;
endpackage : rtcm_pkg

// ==== core/rtcm_regs_if.sv ====
// Interface carrying byte register write strobe and data inside the block.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface rtcm_regs_if;
  logic we;
  logic [7:0] wdata;
  logic [7:0] q;
  modport ctrl (output we, output wdata, input q);
  modport store (input we, input wdata, output q);
endinterface : rtcm_regs_if
`default_nettype wire

// ==== core/rtcm_byte_reg.sv ====
// One byte of register storage with a write mask.
// Assumes writes are single-cycle strobes from the bus decode.
`timescale 1ns/1ps
`default_nettype none
module rtcm_byte_reg #(
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Storage port
  rtcm_regs_if.store port
);
  logic [7:0] value;

  // Masked bits keep their old value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value <= RESET_VAL;
    else if (clk_en && port.we)
      value <= (port.wdata & WMASK) | (value & ~WMASK);
  end

  assign port.q = value;
endmodule : rtcm_byte_reg
`default_nettype wire

// ==== tb/rtcm_properties.sv ====
// Checker of the register map's APB answers and control outputs.
// Assumes the byte address is four times the register index.
`timescale 1ns/1ps
`default_nettype none
module rtcm_properties #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status in, control out
  input wire logic [3:0] irq_flag_bits,
  input wire logic battery_good_flag,
  input wire logic data_format_select,
  input wire logic bank_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Answer timing: one wait cycle, one-cycle pulse
  // A low clock enable freezes pready, so both timing checks need it high
  ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("pready held");
  ready_wait_a: assert property (clk_en && psel && penable && !pready |=> pready)
    else $error("no answer");
  ready_cause_a: assert property (pready |-> psel && penable) else $error("stray pready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper");
  // Fixed zero bits of the status bytes; slave error for out-of-range addresses
  flags_low_a: assert property (pready && !pwrite && paddr == 12'h030
    |-> prdata[7:0] == {irq_flag_bits, 4'h0}) else $error("flag byte");
  battery_low_a: assert property (pready && !pwrite && paddr == 12'h034
    |-> prdata[7:0] == {battery_good_flag, 7'h00}) else $error("battery byte");
  unmapped_err_a: assert property (pready && paddr[11:10] != 2'b00 |-> pslverr)
    else $error("no slave error");
  // Selector outputs follow the written control bits
  format_copy_a: assert property (pready && pwrite && pstrb[0] && paddr == 12'h02C
    |=> data_format_select == $past(pwdata[2])) else $error("format bit");
  bank_copy_a: assert property (pready && pwrite && pstrb[0] && paddr == 12'h028
    |=> bank_select == $past(pwdata[4])) else $error("bank bit");
  cover property (pready && pslverr);
  cover property (!clk_en && psel && penable);
  cover property (pready && pwrite && paddr == 12'h02C);
  cover property (pready && !pwrite && paddr == 12'h120 && !pslverr);
endmodule : rtcm_properties
bind rtcm_top rtcm_properties #(.ADDR_W(ADDR_W)) chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_flag_bits(irq_flag_bits), .battery_good_flag(battery_good_flag),
  .data_format_select(data_format_select), .bank_select(bank_select));
`default_nettype wire

// ==== tb/rtcm_apb_host.sv ====
// Host model: APB master issuing one byte register transfer at a time.
// Assumes the slave answers with pready; the bench watchdog ends a hang.
`timescale 1ns/1ps
`default_nettype none
module rtcm_apb_host (
  // Clock
  input wire logic clk,
  // APB
  output var logic psel = 1'b0,
  output var logic penable = 1'b0,
  output var logic pwrite = 1'b0,
  output var logic [11:0] paddr = 12'h000,
  output var logic [31:0] pwdata = 32'h00000000,
  output var logic [3:0] pstrb = 4'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Setup, access, hold until pready; released lines show junk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic s, output logic [7:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= {3'h0, s};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : rtcm_apb_host
`default_nettype wire

// ==== tb/rtcm_tb_top.sv ====
// Self-checking bench of the clock calendar register map.
// Assumes the host model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module rtcm_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic upf = 1'b1;
  logic bat = 1'b1;
  logic cen = 1'b1;
  logic [3:0] any_irq_flag = 4'hA;
  logic psel, penable, pwrite, pready, pslverr, fmt, h24, bank, amatch, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] r;
  int err_count = 0;
  int n_tests = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  rtcm_apb_host h (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  rtcm_top dut (.clk(clk), .rst_n(rst_n), .clk_en(cen), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .update_pending_flag(upf), .irq_flag_bits(any_irq_flag),
    .battery_good_flag(bat), .data_format_select(fmt), .hour_24_select(h24),
    .bank_select(bank), .alarm_match(amatch));
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    h.xfer(1'b1, {2'b00, o, 2'b00}, d, 1'b1, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [7:0] x);
    h.xfer(1'b0, {2'b00, o, 2'b00}, 8'h00, 1'b1, r, e);
    `CHK({e, r}, {1'b0, x})
  endtask : rd
  // Reset values and read-only places
  task automatic t_ctrl;
    rd(rtcm_pkg::ADDR_RATE_CTRL, 8'hA0);
    rd(rtcm_pkg::ADDR_IRQ_FMT_CTRL, 8'h00);
    wr(rtcm_pkg::ADDR_IRQ_FLAGS, 8'hFF);
    any_irq_flag <= 4'h5;
    rd(rtcm_pkg::ADDR_IRQ_FLAGS, 8'h50);
    wr(rtcm_pkg::ADDR_BATTERY, 8'hFF);
    rd(rtcm_pkg::ADDR_BATTERY, 8'h80);
    wr(rtcm_pkg::ADDR_RATE_CTRL, 8'hAF);
    upf <= 1'b0;
    rd(rtcm_pkg::ADDR_RATE_CTRL, 8'h2F);
    wr(rtcm_pkg::ADDR_RATE_CTRL, 8'h20);
    wr(rtcm_pkg::ADDR_SECONDS, 8'hD9);
    rd(rtcm_pkg::ADDR_SECONDS, 8'h59);
  endtask : t_ctrl
  // Extended bytes only while bank one is selected
  task automatic t_bank;
    h.xfer(1'b0, 12'h120, 8'h00, 1'b1, r, e);
    `CHK(e, 1'b1)
    // Address bits above the index must be zero, else a slave error
    h.xfer(1'b0, 12'h400, 8'h00, 1'b1, r, e);
    `CHK(e, 1'b1)
    wr(rtcm_pkg::ADDR_RATE_CTRL, 8'h30);
    @(posedge clk);
    `CHK(bank, 1'b1)
    wr(rtcm_pkg::ADDR_CENTURY, 8'h20);
    rd(rtcm_pkg::ADDR_CENTURY, 8'h20);
    wr(rtcm_pkg::ADDR_ALARM_DATE, 8'h31);
    rd(rtcm_pkg::ADDR_ALARM_DATE, 8'h31);
    rd(rtcm_pkg::ADDR_IRQ_FMT_CTRL, 8'h00);
    wr(rtcm_pkg::ADDR_RATE_CTRL, 8'h20);
  endtask : t_bank
  // Binary and decimal formats, hour forms, writable zero bits
  task automatic t_fmt;
    wr(rtcm_pkg::ADDR_IRQ_FMT_CTRL, 8'h06);
    @(posedge clk);
    `CHK({fmt, h24}, 2'b11)
    wr(rtcm_pkg::ADDR_MINUTES, 8'h3B);
    rd(rtcm_pkg::ADDR_MINUTES, 8'h3B);
    wr(rtcm_pkg::ADDR_IRQ_FMT_CTRL, 8'h00);
    @(posedge clk);
    `CHK({fmt, h24}, 2'b00)
    wr(rtcm_pkg::ADDR_HOURS, 8'h92);
    rd(rtcm_pkg::ADDR_HOURS, 8'h92);
    for (int i = 1; i < 10; i++)
    begin
      wr(8'(i), 8'hFF);
      rd(8'(i), 8'hFF);
    end
    h.xfer(1'b1, 12'h008, 8'h11, 1'b0, r, e);
    rd(rtcm_pkg::ADDR_MINUTES, 8'hFF);
  endtask : t_fmt
  // Alarm bytes are all ones here, so they match anything
  task automatic t_alarm;
    @(posedge clk);
    `CHK(amatch, 1'b1)
    wr(rtcm_pkg::ADDR_ALARM_SECONDS, 8'h05);
    wr(rtcm_pkg::ADDR_SECONDS, 8'h07);
    repeat (2) @(posedge clk);
    `CHK(amatch, 1'b0)
    wr(rtcm_pkg::ADDR_SECONDS, 8'h05);
    repeat (2) @(posedge clk);
    `CHK(amatch, 1'b1)
    // Clock enable low freezes the bus answer and every byte
    cen <= 1'b0;
    fork
      wr(rtcm_pkg::ADDR_SECONDS, 8'h07);
      begin
        repeat (4) @(posedge clk);
        `CHK({pready, amatch}, 2'b01)
        cen <= 1'b1;
      end
    join
    repeat (2) @(posedge clk);
    `CHK(amatch, 1'b0)
  endtask : t_alarm
  task automatic wrap_up;
    $display("Mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Main sequence after 16 reset cycles
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_ctrl;
    t_bank;
    t_fmt;
    t_alarm;
    wrap_up;
  end
  // Watchdog, far above the few hundred cycles needed
  initial
  begin
    #250000;
    err_count++;
    wrap_up;
  end
endmodule : rtcm_tb_top
`default_nettype wire
